// ===== logic/pse_pkg.sv
/*
  pse_pkg: register offsets, reset values, field positions and effect
  mode codes for the pixel special-effects stage.
  assumes: imported by pse_fifo and pse_top of the stage.
*/
package pse_pkg;

  // register word indices on the internal register path
  localparam logic [8:0]  PSE_ADDR_EFFECT_SELECT  = 9'h1e2;
  localparam logic [8:0]  PSE_ADDR_SEPIA_CHROMA   = 9'h1e3;

  // reset values
  localparam logic [15:0] PSE_RST_EFFECT_SELECT   = 16'h7000;
  localparam logic [15:0] PSE_RST_SEPIA_CHROMA    = 16'hb023;

  // effect_select_control fields
  localparam int          PSE_MODE_LSB            = 0;
  localparam int          PSE_MODE_W              = 3;
  localparam int          PSE_THRESH_LSB          = 8;
  localparam int          PSE_THRESH_W            = 8;

  // sepia_chroma_values fields
  localparam int          PSE_CR_LSB              = 0;
  localparam int          PSE_CB_LSB              = 8;
  localparam int          PSE_SM_W                = 8;

  // effect mode codes
  localparam logic [2:0]  PSE_MODE_NONE           = 3'h0;
  localparam logic [2:0]  PSE_MODE_MONO           = 3'h1;
  localparam logic [2:0]  PSE_MODE_SEPIA          = 3'h2;
  localparam logic [2:0]  PSE_MODE_NEGATIVE       = 3'h3;
  localparam logic [2:0]  PSE_MODE_SOLAR1         = 3'h4;
  localparam logic [2:0]  PSE_MODE_SOLAR2         = 3'h5;

  // pixel layout: luma in the top byte, then cb, then cr
  localparam int          PSE_COMP_W              = 8;
  localparam int          PSE_PIX_W               = 24;
  localparam int          PSE_FIFO_DEPTH          = 8;

endpackage : pse_pkg

// ===== logic/pse_stream_if.sv
/*
  pse_stream_if: valid/ready word stream between the effect stage and
  its output buffer.
  assumes: both ends on the same clock; a word moves when valid and
  ready are both high at a clock edge.
*/
`timescale 1ns/10ps
interface pse_stream_if #(
  parameter int WIDTH = 24
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pse_stream_if

// ===== logic/pse_fifo.sv
/*
  pse_fifo: synchronous first-in first-out buffer with valid/ready on
  both sides and parameters for width and depth.
  assumes: single clock, depth a power of two, asynchronous reset.
*/
`timescale 1ns/10ps
module pse_fifo
  import pse_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  pse_stream_if.snk             wr,
  output      logic             rd_valid,
  input  wire logic             rd_ready,
  output      logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              full;
  wire              empty;
  wire              push;
  wire              pop;

  // full when pointers differ only in the wrap bit
  assign full     = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                    (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty    = (wr_ptr_q == rd_ptr_q);
  assign wr.ready = !full;
  assign push     = wr.valid && !full;
  assign rd_valid = !empty;
  assign pop      = rd_ready && !empty;
  assign rd_data  = mem_q[rd_ptr_q[AW-1:0]]; // read from storage flops

  // storage write, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr.data;
    end
  end

  // pointer update
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
      rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
    end
  end
endmodule : pse_fifo

// ===== logic/pse_top.sv
/*
  pse_top: special-effects stage of the colour pipeline. it takes ycbcr
  pixels from upstream, applies the effect chosen in its control
  register, and hands them through an output buffer downstream.
  assumes: upstream and downstream are logic on ref_clk; chroma is
  carried as signed two's complement bytes, zero meaning no colour;
  the register path comes from the serial interface's page decoder.
*/
`timescale 1ns/10ps

// Operation
// [RULE1] mode zero forwards pixels unchanged
// [RULE2] monochrome forces both chromas to zero
// [RULE3] sepia replaces chromas with programmed pair
// [RULE4] negative inverts luma and both chromas
// [RULE5] solarize one inverts luma past threshold
// [RULE6] solarize two also inverts those chromas
// [RULE7] threshold is control register upper byte
// [RULE8] sepia cb is sign and magnitude
// [RULE9] sepia cr is sign and magnitude
// [RULE10] any sepia chroma pair is accepted
// [RULE11] threshold means above; unused codes pass
module pse_top
  import pse_pkg::*;
#(
  parameter int FIFO_DEPTH = PSE_FIFO_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // register path
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [8:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output      logic [15:0]           reg_rdata,
  output      logic                  reg_rvalid,
  // pixels from upstream
  input  wire logic                  in_valid,
  output      logic                  in_ready,
  input  wire logic [PSE_COMP_W-1:0] in_y,
  input  wire logic [PSE_COMP_W-1:0] in_cb,
  input  wire logic [PSE_COMP_W-1:0] in_cr,
  // pixels to downstream
  output      logic                  out_valid,
  input  wire logic                  out_ready,
  output      logic [PSE_COMP_W-1:0] out_y,
  output      logic [PSE_COMP_W-1:0] out_cb,
  output      logic [PSE_COMP_W-1:0] out_cr
);

  // sign-magnitude 0.7 chroma to two's complement byte
  function automatic logic [PSE_COMP_W-1:0] sm_to_tc(
    input logic [PSE_SM_W-1:0] sm
  );
    logic [PSE_COMP_W-1:0] mag;
    mag = {1'b0, sm[PSE_SM_W-2:0]};
    return sm[PSE_SM_W-1] ? PSE_COMP_W'(~mag + 8'h01) : mag;
  endfunction : sm_to_tc

  // registers
  logic [15:0]           effect_select_q;
  logic [15:0]           sepia_chroma_q;
  logic [15:0]           rdata_q;
  logic                  rvalid_q;

  // effect stage holding register
  logic                  stg_valid_q;
  logic [PSE_PIX_W-1:0]  stg_pix_q;

  // register decode
  wire                   hit_effect;
  wire                   hit_sepia;
  wire  [15:0]           rd_mux;

  assign hit_effect = (reg_addr == PSE_ADDR_EFFECT_SELECT);
  assign hit_sepia  = (reg_addr == PSE_ADDR_SEPIA_CHROMA);
  assign rd_mux     = hit_effect ? effect_select_q :
                      hit_sepia  ? sepia_chroma_q  : 16'h0000;

  // register writes take effect from the next pixel onward
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      effect_select_q <= PSE_RST_EFFECT_SELECT;
      sepia_chroma_q  <= PSE_RST_SEPIA_CHROMA;
    end else if (reg_wr) begin
      if (hit_effect) begin
        effect_select_q <= reg_wdata;
      end
      // [RULE10] any pair stored
      if (hit_sepia) begin
        sepia_chroma_q <= reg_wdata;
      end
    end
  end

  // read answer one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // control fields
  wire  [PSE_MODE_W-1:0]   mode;
  wire  [PSE_THRESH_W-1:0] thresh;
  wire  [PSE_COMP_W-1:0]   sepia_cb;
  wire  [PSE_COMP_W-1:0]   sepia_cr;

  assign mode     = effect_select_q[PSE_MODE_LSB +: PSE_MODE_W];
  // [RULE7] threshold upper byte
  assign thresh   = effect_select_q[PSE_THRESH_LSB +: PSE_THRESH_W];
  // [RULE8] cb sign magnitude
  assign sepia_cb = sm_to_tc(sepia_chroma_q[PSE_CB_LSB +: PSE_SM_W]);
  // [RULE9] cr sign magnitude
  assign sepia_cr = sm_to_tc(sepia_chroma_q[PSE_CR_LSB +: PSE_SM_W]);

  // mode decode
  wire                   is_mono;
  wire                   is_sepia;
  wire                   is_neg;
  wire                   is_sol1;
  wire                   is_sol2;
  wire                   over_thresh;
  wire                   sol_flip;

  assign is_mono     = (mode == PSE_MODE_MONO);
  assign is_sepia    = (mode == PSE_MODE_SEPIA);
  assign is_neg      = (mode == PSE_MODE_NEGATIVE);
  assign is_sol1     = (mode == PSE_MODE_SOLAR1);
  assign is_sol2     = (mode == PSE_MODE_SOLAR2);
  // [RULE11] strictly above threshold
  assign over_thresh = (in_y > thresh);
  assign sol_flip    = (is_sol1 || is_sol2) && over_thresh;

  // effect selection per component
  wire  [PSE_COMP_W-1:0] fx_y;
  wire  [PSE_COMP_W-1:0] fx_cb;
  wire  [PSE_COMP_W-1:0] fx_cr;
  wire                   flip_y;
  wire                   flip_c;

  // [RULE4] negative inverts everything
  // [RULE5] solarize luma flip
  assign flip_y = is_neg || sol_flip;
  // [RULE6] chroma follows luma flip, except in solarize one
  assign flip_c = is_neg || (is_sol2 && over_thresh);

  // [RULE1] untouched unless selected
  // [RULE11] unused codes pass
  assign fx_y  = flip_y ? ~in_y : in_y;
  // [RULE2] mono zero chroma
  // [RULE3] sepia chroma pair
  assign fx_cb = is_mono  ? 8'h00    :
                 is_sepia ? sepia_cb :
                 flip_c   ? ~in_cb   : in_cb;
  assign fx_cr = is_mono  ? 8'h00    :
                 is_sepia ? sepia_cr :
                 flip_c   ? ~in_cr   : in_cr;

  // output buffer link
  pse_stream_if #(.WIDTH(PSE_PIX_W)) buf_if ();

  wire                   take_in;
  wire                   stg_move;

  assign stg_move     = stg_valid_q && buf_if.ready;
  // stage accepts when empty or draining this cycle
  assign in_ready     = !stg_valid_q || buf_if.ready;
  assign take_in      = in_valid && in_ready;
  assign buf_if.valid = stg_valid_q;
  assign buf_if.data  = stg_pix_q;

  // effect stage register, back-pressure comes from the buffer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stg_valid_q <= 1'b0;
      stg_pix_q   <= '0;
    end else begin
      if (take_in) begin
        stg_valid_q <= 1'b1;
        stg_pix_q   <= {fx_y, fx_cb, fx_cr};
      end else if (stg_move) begin
        stg_valid_q <= 1'b0;
      end
    end
  end

  // eight-word output buffer
  logic [PSE_PIX_W-1:0]  out_pix;

  pse_fifo #(
    .WIDTH (PSE_PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .wr       (buf_if.snk),
    .rd_valid (out_valid),
    .rd_ready (out_ready),
    .rd_data  (out_pix)
  );

  // unpack the buffered pixel
  assign out_y  = out_pix[2*PSE_COMP_W +: PSE_COMP_W];
  assign out_cb = out_pix[PSE_COMP_W   +: PSE_COMP_W];
  assign out_cr = out_pix[0            +: PSE_COMP_W];

endmodule : pse_top

// ===== testbench/pse_sink.sv
/*
  pse_sink: downstream formatter model collecting the stage's pixels.
  assumes: the bench drives hold; otherwise it stalls at random.
*/
`timescale 1ns/10ps
module pse_sink (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        hold,
  input  wire logic        out_valid,
  output      logic        out_ready,
  input  wire logic [23:0] pix
);
  logic [23:0] got[$];

  // random stalls, changed away from the sampling edge
  initial out_ready = 1'b0;
  always @(negedge ref_clk) out_ready <= !hold && ($urandom_range(3) != 0);

  // keep every word taken, in order
  always @(posedge ref_clk)
    if (arst_n && out_valid && out_ready) got.push_back(pix);
endmodule : pse_sink

// ===== testbench/pse_chk.sv
/*
  pse_chk: port assertions for the effect stage.
  assumes: bound to pse_top; one clock, async active-low reset.
*/
`timescale 1ns/10ps
module pse_chk
  import pse_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [8:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic [7:0]  in_y,
  input wire logic [7:0]  in_cb,
  input wire logic [7:0]  in_cr,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_y,
  input wire logic [7:0]  out_cb,
  input wire logic [7:0]  out_cr
);
  logic        fire_q;
  logic [15:0] ctl_q;
  logic [15:0] sep_q;

  // a lone pixel enters an empty stage and buffer
  wire        fire = in_valid & in_ready;
  wire        lone = fire & !out_valid & !fire_q;
  wire [2:0]  mode = ctl_q[2:0];
  wire [23:0] pin  = {in_y, in_cb, in_cr};
  wire [23:0] pout = {out_y, out_cb, out_cr};
  wire        map  = reg_addr == PSE_ADDR_EFFECT_SELECT
                  || reg_addr == PSE_ADDR_SEPIA_CHROMA;

  // expected sepia pair, sign and magnitude to two's complement
  wire [7:0]  s_cb = sep_q[15] ? 8'h00 - {1'b0, sep_q[14:8]}
                               : {1'b0, sep_q[14:8]};
  wire [7:0]  s_cr = sep_q[7] ? 8'h00 - {1'b0, sep_q[6:0]}
                              : {1'b0, sep_q[6:0]};
  wire [15:0] s_pair = {s_cb, s_cr};

  // shadow of both register words and the last acceptance
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fire_q <= 1'b0;
      ctl_q  <= PSE_RST_EFFECT_SELECT;
      sep_q  <= PSE_RST_SEPIA_CHROMA;
    end else begin
      fire_q <= fire;
      if (reg_wr && reg_addr == PSE_ADDR_EFFECT_SELECT) ctl_q <= reg_wdata;
      if (reg_wr && reg_addr == PSE_ADDR_SEPIA_CHROMA) sep_q <= reg_wdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer missing");
  property p_rd_one; !reg_rd |=> !reg_rvalid; endproperty
  a_rd_one: assert property (p_rd_one)
    else $error("read answer without read");
  property p_back;
    reg_wr && map ##1 reg_rd && !reg_wr && $stable(reg_addr)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_back: assert property (p_back)
    else $error("register readback differs");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(pout);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed while stalled");
  property p_full; !in_ready |-> out_valid; endproperty
  a_full: assert property (p_full)
    else $error("input refused with empty buffer");
  property p_pass;
    lone && (mode == PSE_MODE_NONE || mode > PSE_MODE_SOLAR2)
      |-> ##2 out_valid && pout == $past(pin, 2);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass mode altered pixel");
  property p_mono;
    lone && mode == PSE_MODE_MONO |-> ##2 pout == {$past(in_y, 2), 16'h0000};
  endproperty
  a_mono: assert property (p_mono)
    else $error("monochrome pixel wrong");
  property p_neg;
    lone && mode == PSE_MODE_NEGATIVE |-> ##2 pout == ~$past(pin, 2);
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative pixel wrong");
  property p_sol;
    lone && mode == PSE_MODE_SOLAR1 && in_y > ctl_q[15:8]
      |-> ##2 pout == {~$past(in_y, 2), $past(pin[15:0], 2)};
  endproperty
  a_sol: assert property (p_sol)
    else $error("solarize pixel wrong");
  property p_sepia;
    lone && mode == PSE_MODE_SEPIA
      |-> ##2 pout == {$past(in_y, 2), $past(s_pair, 2)};
  endproperty
  a_sepia: assert property (p_sepia)
    else $error("sepia pixel wrong");
  property p_sol2;
    lone && mode == PSE_MODE_SOLAR2 && in_y > ctl_q[15:8]
      |-> ##2 pout == ~$past(pin, 2);
  endproperty
  a_sol2: assert property (p_sol2)
    else $error("second solarize pixel wrong");
  property p_keep;
    lone && (mode == PSE_MODE_SOLAR1 || mode == PSE_MODE_SOLAR2)
      && in_y <= ctl_q[15:8] |-> ##2 pout == $past(pin, 2);
  endproperty
  a_keep: assert property (p_keep)
    else $error("pixel at or below threshold altered");

  c_sol2: cover property (lone && mode == PSE_MODE_SOLAR2);
  c_sepia: cover property (lone && mode == PSE_MODE_SEPIA);
  c_full: cover property (!in_ready);
endmodule : pse_chk

bind pse_top pse_chk i_pse_chk (.*);

// ===== testbench/tb_pixel_special_effects.sv
/*
  tb_pixel_special_effects: random and corner tests of pse_top.
  assumes: pse_sink takes the output side; pse_chk is bound.
*/
`timescale 1ns/10ps
module tb_pixel_special_effects
  import pse_pkg::*;
;
  logic        ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, hold = 0;
  logic        in_valid = 0, reg_rvalid, in_ready, out_valid, out_ready;
  logic [8:0]  reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, ctl, sep;
  logic [7:0]  in_y = '0, in_cb = '0, in_cr = '0, out_y, out_cb, out_cr;
  logic [23:0] px, exp_q[$];
  int          err_count = 0, checks_done = 0, cyc = 0;

  pse_top i_pse_top (.*);
  pse_sink i_pse_sink (.ref_clk(ref_clk), .arst_n(arst_n), .hold(hold),
    .out_valid(out_valid), .out_ready(out_ready), .pix({out_y, out_cb, out_cr}));

  initial forever #2 ref_clk = ~ref_clk;

  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end

  task chk(input string n, input logic [23:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [8:0] a, input logic [15:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk) reg_wr = 0;
  endtask : wr

  task rd(input logic [8:0] a, input logic [15:0] e);
    reg_rd = 1;
    reg_addr = a;
    @(negedge ref_clk) reg_rd = 0;
    chk("reg_rvalid", reg_rvalid, 1'b1);
    chk("reg_rdata", reg_rdata, e);
    // strobe rests one cycle so a following read is a fresh pulse
    @(negedge ref_clk);
  endtask : rd

  task cfg(input logic [15:0] c, s);
    ctl = c;
    sep = s;
    wr(PSE_ADDR_EFFECT_SELECT, c);
    rd(PSE_ADDR_EFFECT_SELECT, c);
    wr(PSE_ADDR_SEPIA_CHROMA, s);
    rd(PSE_ADDR_SEPIA_CHROMA, s);
  endtask : cfg

  // sign and magnitude to two's complement
  function logic [7:0] sm(input logic [7:0] v);
    return v[7] ? 8'h00 - {1'b0, v[6:0]} : {1'b0, v[6:0]};
  endfunction : sm

  function logic [23:0] fx(input logic [23:0] p);
    logic inv;
    inv = p[23:16] > ctl[15:8];
    case (ctl[2:0])
      PSE_MODE_MONO:     return {p[23:16], 16'h0000};
      PSE_MODE_SEPIA:    return {p[23:16], sm(sep[15:8]), sm(sep[7:0])};
      PSE_MODE_NEGATIVE: return ~p;
      PSE_MODE_SOLAR1:   return inv ? {~p[23:16], p[15:0]} : p;
      PSE_MODE_SOLAR2:   return inv ? ~p : p;
      default:           return p;
    endcase
  endfunction : fx

  task send(input logic [23:0] p);
    while (in_ready !== 1'b1) begin
      in_valid = 0;
      @(negedge ref_clk);
    end
    {in_y, in_cb, in_cr} = p;
    in_valid = 1;
    exp_q.push_back(fx(p));
    @(negedge ref_clk);
  endtask : send

  task drain;
    logic [23:0] e, g;
    in_valid = 0;
    {in_y, in_cb, in_cr} = 24'($urandom);
    hold = 0;
    while (i_pse_sink.got.size() < exp_q.size()) @(negedge ref_clk);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      g = i_pse_sink.got.pop_front();
      chk("luma", g[23:16], e[23:16]);
      chk("chroma", g[15:0], e[15:0]);
    end
    @(negedge ref_clk);
  endtask : drain

  task end_of_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(71783));
    repeat (16) @(negedge ref_clk);
    arst_n = 1;
    rd(PSE_ADDR_EFFECT_SELECT, PSE_RST_EFFECT_SELECT);
    rd(PSE_ADDR_SEPIA_CHROMA, PSE_RST_SEPIA_CHROMA);
    wr(9'h1e4, 16'hffff);
    rd(9'h1e4, 16'h0000);
    rd(PSE_ADDR_EFFECT_SELECT, PSE_RST_EFFECT_SELECT);
    // every mode code, default then random sepia, threshold corners
    for (int r = 0; r < 2; r++) begin
      for (int m = 0; m < 8; m++) begin
        px = 24'($urandom);
        cfg({px[15:3], m[2:0]}, r ? px[23:8] : PSE_RST_SEPIA_CHROMA);
        send({ctl[15:8] + 8'h01, px[15:0]});
        send({ctl[15:8], px[15:0]});
        repeat (10) send(24'($urandom));
        drain;
      end
    end
    // stalled downstream: stage plus buffer hold nine pixels
    hold = 1;
    cfg(PSE_RST_EFFECT_SELECT, PSE_RST_SEPIA_CHROMA);
    repeat (9) send(24'($urandom));
    chk("in_ready", in_ready, 1'b0);
    drain;
    end_of_test;
  end
endmodule : tb_pixel_special_effects
